/* File: design/crf_cpu_regs.sv */
`timescale 1ns/1ns
module crf_cpu_regs
  import crf_pkg::*;
#(
  parameter bit SEGMENTED = 1'b1,
  parameter int NUM_GPR   = 16
)(
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic [8:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic      [3:0]  bus_status_code,
  output logic      [22:0] bus_address,
  output logic             bus_strobe,
  output logic             normal_system
);
  if (NUM_GPR != 16) begin : g_chk
    $error("crf_cpu_regs supports exactly 16 word registers");
  end

  // ==========================================================
  // state
  logic [15:0] gpr_q [16];
  logic [15:0] ssp_q [2];
  logic [15:0] fcw_q;
  logic [15:0] fcw_d;
  logic [31:0] pc_q;
  logic [15:0] saved_q;
  logic [1:0]  stat_q;
  logic        wait_q;
  logic [31:0] rdata_q;
  logic [3:0]  code_q;
  logic [22:0] addr_q;
  logic        strobe_q;
  logic        normal_q;

  wire logic       sys_mode = fcw_q[FCW_SYS];
  wire logic [8:0] a        = avs_address;
  wire logic [2:0] bv_word  = a[5:3];
  wire logic       bus_wr   = avs_write & ~wait_q;
  wire logic       bus_rd   = avs_read & wait_q;
  wire logic       spec_wr  = bus_wr & (a == OFF_FCW || a == OFF_PC || a == OFF_NSP);
  wire logic       priv_ok  = spec_wr & sys_mode;
  wire logic       alu_go   = bus_wr & (a == OFF_ALU);
  wire logic       acc_go   = bus_wr & (a == OFF_BUS);
  wire logic       trap_go  = bus_wr & (a == OFF_TRAP);

  // ==========================================================
  // decoding shared by read and write paths
  function automatic crf_rgn_e rgn(input logic [8:0] ad);
    if (ad[8:6] == 3'h0) return RG_WORD;
    if (ad[8:6] == OFF_BYTE[8:6]) return RG_BYTE;
    if (ad[8:5] == OFF_PAIR[8:5]) return RG_PAIR;
    if (ad[8:5] == OFF_QUAD[8:5]) return RG_QUAD;
    return RG_NONE;
  endfunction

  // the stack slots swap to the system pointer only in system mode
  function automatic logic sys_slot(input logic [3:0] i);
    return sys_mode && (i == SP_LO || (SEGMENTED && i == SP_HI));
  endfunction

  function automatic logic [15:0] vis_rd(input logic [3:0] i);
    if (sys_slot(i)) return ssp_q[i[0]];
    return gpr_q[i];
  endfunction

  function automatic logic [7:0] byte_rd(input logic [3:0] idx);
    logic [15:0] w;
    w = vis_rd({1'b0, idx[3:1]});
    return idx[0] ? w[7:0] : w[15:8];
  endfunction

  crf_rgn_e rg;
  assign rg = rgn(a);

  // ==========================================================
  // arithmetic and flags
  logic [15:0] op_a;
  logic [15:0] op_b;
  logic [16:0] sum;
  logic [15:0] res;
  logic        res_zero;
  logic        res_neg;
  logic        is_byte;
  logic [3:0]  dst;
  crf_alu_e    op;

  always_comb begin
    op      = crf_alu_e'(avs_writedata[1:0]);
    is_byte = avs_writedata[2];
    dst     = avs_writedata[7:4];
    op_a    = is_byte ? {8'h00, byte_rd(dst)} : vis_rd(dst);
    op_b    = is_byte ? {8'h00, byte_rd(avs_writedata[11:8])} : vis_rd(avs_writedata[11:8]);
    sum     = (op == ALU_SUB) ? {1'b0, op_a} - {1'b0, op_b} : {1'b0, op_a} + {1'b0, op_b};
    case (op)
      ALU_AND: res = op_a & op_b;
      ALU_XOR: res = op_a ^ op_b;
      default: res = sum[15:0];
    endcase
    res_zero = is_byte ? (res[7:0] == 8'h00) : (res == 16'h0000);
    res_neg  = is_byte ? res[7] : res[15];
  end

  always_comb begin
    logic am;
    logic bm;
    am    = is_byte ? op_a[7] : op_a[15];
    bm    = is_byte ? op_b[7] : op_b[15];
    fcw_d = fcw_q;
    if (alu_go) begin
      fcw_d[FCW_Z] = res_zero;
      fcw_d[FCW_S] = res_neg;
      if (op == ALU_ADD || op == ALU_SUB) begin
        fcw_d[FCW_C] = is_byte ? sum[8] : sum[16];
        fcw_d[FCW_V] = (am ^ res_neg) & ((op == ALU_SUB) ? (am ^ bm) : ~(am ^ bm));
        fcw_d[FCW_D] = (op == ALU_SUB);
        fcw_d[FCW_H] = op_a[4] ^ op_b[4] ^ res[4];
      end else if (is_byte) begin
        fcw_d[FCW_V] = ~^res[7:0];
      end
    end
    if (priv_ok && a == OFF_FCW) begin
      fcw_d          = avs_writedata[15:0];
      fcw_d[FCW_SEG] = SEGMENTED;
    end
    if (trap_go) begin
      fcw_d[FCW_SYS] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      fcw_q    <= FCW_RST | {SEGMENTED, 15'h0000};
      normal_q <= ~FCW_RST[FCW_SYS];
    end else begin
      fcw_q    <= fcw_d;
      normal_q <= ~fcw_d[FCW_SYS];
    end
  end

  // ==========================================================
  // register writes through the word, byte, pair and quad views
  logic        wen [16];
  logic [15:0] wdat [16];

  always_comb begin
    logic [15:0] w;
    logic [3:0]  bi;
    w  = 16'h0000;
    bi = 4'h0;
    for (int i = 0; i < 16; i++) begin
      wen[i]  = 1'b0;
      wdat[i] = 16'h0000;
    end
    if (bus_wr && rg == RG_WORD) begin
      wen[a[5:2]]  = 1'b1;
      wdat[a[5:2]] = avs_writedata[15:0];
    end
    if (bus_wr && rg == RG_PAIR) begin
      wen[{a[4:2], 1'b0}]  = 1'b1;
      wdat[{a[4:2], 1'b0}] = avs_writedata[31:16];
      wen[{a[4:2], 1'b1}]  = 1'b1;
      wdat[{a[4:2], 1'b1}] = avs_writedata[15:0];
    end
    if (bus_wr && rg == RG_QUAD) begin
      wen[{a[4:2], 1'b0}]  = 1'b1;
      wdat[{a[4:2], 1'b0}] = avs_writedata[31:16];
      wen[{a[4:2], 1'b1}]  = 1'b1;
      wdat[{a[4:2], 1'b1}] = avs_writedata[15:0];
    end
    if ((bus_wr && rg == RG_BYTE) || (alu_go && is_byte)) begin
      bi = alu_go ? dst : a[5:2];
      w  = vis_rd({1'b0, bi[3:1]});
      if (bi[0]) w[7:0] = alu_go ? res[7:0] : avs_writedata[7:0];
      else w[15:8] = alu_go ? res[7:0] : avs_writedata[7:0];
      wen[{1'b0, bi[3:1]}]  = 1'b1;
      wdat[{1'b0, bi[3:1]}] = w;
    end
    if (alu_go && !is_byte) begin
      wen[dst]  = 1'b1;
      wdat[dst] = res;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      for (int i = 0; i < 16; i++) gpr_q[i] <= 16'h0000;
      ssp_q[0] <= 16'h0000;
      ssp_q[1] <= 16'h0000;
    end else begin
      for (int i = 0; i < 16; i++) begin
        if (wen[i] && sys_slot(4'(i))) ssp_q[i % 2] <= wdat[i];
        else if (wen[i]) gpr_q[i] <= wdat[i];
      end
      if (priv_ok && a == OFF_NSP) begin
        if (SEGMENTED) gpr_q[SP_HI] <= avs_writedata[31:16];
        gpr_q[SP_LO] <= avs_writedata[15:0];
      end
      // status save space comes off the system pointer only
      if (trap_go) begin
        ssp_q[1] <= ssp_q[1] - (SEGMENTED ? PS_BYTES_SEG : PS_BYTES_NSEG);
      end
    end
  end

  // ==========================================================
  // program status
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pc_q    <= 32'h0000_0000;
      saved_q <= 16'h0000;
    end else begin
      if (priv_ok && a == OFF_PC) begin
        pc_q <= SEGMENTED ? avs_writedata : {16'h0000, avs_writedata[15:0]};
      end
      if (trap_go) saved_q <= fcw_q;
    end
  end

  // ==========================================================
  // outgoing bus access
  always_ff @(posedge sys_clk) begin
    logic [22:0] ma;
    logic [15:0] sp_hi;
    sp_hi = vis_rd(SP_HI);
    ma    = avs_writedata[30:8];
    if (srst) begin
      code_q   <= ST_INTERNAL;
      addr_q   <= 23'h000000;
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= 1'b0;
      if (acc_go) begin
        strobe_q <= 1'b1;
        if (!SEGMENTED) ma[22:16] = 7'h00;
        case (crf_acc_e'(avs_writedata[2:0]))
          ACC_FETCH: code_q <= ST_IFETCH;
          ACC_DATA:  code_q <= ST_DATA;
          ACC_STACK: code_q <= ST_STACK;
          ACC_IO:    code_q <= ST_IO;
          ACC_SPIO:  code_q <= ST_SPIO;
          default: begin
            code_q   <= ST_INTERNAL;
            strobe_q <= 1'b0;
          end
        endcase
        if (avs_writedata[2:0] == ACC_STACK) begin
          ma = SEGMENTED ? {sp_hi[6:0], vis_rd(SP_LO)} : {7'h00, vis_rd(SP_LO)};
        end
        if (avs_writedata[2:0] == ACC_IO || avs_writedata[2:0] == ACC_SPIO) begin
          ma = {7'h00, avs_writedata[23:8]};
          if (!sys_mode) begin
            code_q   <= ST_INTERNAL;
            strobe_q <= 1'b0;
          end
        end
        addr_q <= ma;
      end
    end
  end

  // ==========================================================
  // sticky refusal flags, write one to clear, a new event wins
  wire logic io_ref = acc_go & ~sys_mode
                    & (avs_writedata[2:0] == ACC_IO || avs_writedata[2:0] == ACC_SPIO);

  always_ff @(posedge sys_clk) begin
    logic [1:0] clr;
    clr = (bus_wr && a == OFF_STAT) ? avs_writedata[1:0] : 2'b00;
    if (srst) begin
      stat_q <= 2'b00;
    end else begin
      stat_q <= stat_q & ~clr;
      if (io_ref) stat_q[STAT_IO_REF] <= 1'b1;
      if (spec_wr && !sys_mode) stat_q[STAT_PRIV_REF] <= 1'b1;
    end
  end

  // ==========================================================
  // bus slave: one wait state, unmapped reads give zero
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q <= ~((avs_read | avs_write) & wait_q);
      if (bus_rd) begin
        rdata_q <= 32'h0000_0000;
        case (rg)
          RG_WORD: rdata_q <= {16'h0000, vis_rd(a[5:2])};
          RG_BYTE: rdata_q <= {24'h000000, byte_rd(a[5:2])};
          RG_PAIR, RG_QUAD: rdata_q <= {vis_rd({a[4:2], 1'b0}), vis_rd({a[4:2], 1'b1})};
          default: begin
            if (sys_mode) begin
              if (a == OFF_FCW) rdata_q <= {16'h0000, fcw_q};
              if (a == OFF_PC) rdata_q <= pc_q;
              if (a == OFF_NSP) rdata_q <= {SEGMENTED ? gpr_q[SP_HI] : 16'h0000, gpr_q[SP_LO]};
              if (a == OFF_SAVED) rdata_q <= {16'h0000, saved_q};
            end
            if (a == OFF_STAT) rdata_q <= {30'h0, stat_q};
          end
        endcase
      end
    end
  end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign bus_status_code = code_q;
  assign bus_address     = addr_q;
  assign bus_strobe      = strobe_q;
  assign normal_system   = normal_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  wire logic [15:0] ssp_lo = ssp_q[1];
  wire logic [7:0]  wd_lo  = avs_writedata[7:0];
  wire logic [22:0] ma_req = avs_writedata[30:8];

  sequence s_req_new;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  a_bus_one_wait: assert property (s_req_new |=> s_answer)
    else $error("slave did not answer after one wait state");
  a_mode_pin: assert property (normal_system == !fcw_q[FCW_SYS])
    else $error("mode pin differs from system bit");
  a_io_refused: assert property (io_ref |=> !bus_strobe && stat_q[STAT_IO_REF])
    else $error("port access ran in normal mode");
  a_io_code: assert property (acc_go && sys_mode && avs_writedata[2:0] == ACC_IO
    |=> bus_strobe && bus_status_code == ST_IO && bus_address[22:16] == 7'h00)
    else $error("standard port access code or width wrong");
  a_data_code: assert property (acc_go && avs_writedata[2:0] == ACC_DATA
    |=> bus_strobe && bus_status_code == ST_DATA)
    else $error("data access code wrong");
  a_mem_span: assert property (acc_go && avs_writedata[2:1] == 2'b00
    |=> bus_address == (SEGMENTED ? $past(ma_req) : {7'h00, $past(ma_req[15:0])}))
    else $error("memory address span wrong");
  a_trap_system: assert property (trap_go |=> fcw_q[FCW_SYS]
    && ssp_lo == 16'($past(ssp_lo) - (SEGMENTED ? PS_BYTES_SEG : PS_BYTES_NSEG)))
    else $error("trap did not enter system mode or move system pointer");
  a_priv_write: assert property (spec_wr && !sys_mode |=> $stable(fcw_q) && $stable(pc_q))
    else $error("special register written in normal mode");
  a_byte_alias: assert property (bus_wr && rg == RG_BYTE && !a[2]
    |=> gpr_q[$past(bv_word)][15:8] == $past(wd_lo))
    else $error("high byte view did not alias word register");
  a_zero_flag: assert property (alu_go |=> fcw_q[FCW_Z] == $past(res_zero)
    && fcw_q[FCW_S] == $past(res_neg))
    else $error("zero or sign flag wrong");
endmodule

/* File: design/crf_pkg.sv */
package crf_pkg;
  // ==========================================================
  // register map (byte addresses; bases of the word, byte, pair and quad windows, one aligned word each for the rest)
  localparam logic [8:0] OFF_WORD  = 9'h000;
  localparam logic [8:0] OFF_FCW   = 9'h040;
  localparam logic [8:0] OFF_PC    = 9'h044;
  localparam logic [8:0] OFF_NSP   = 9'h048;
  localparam logic [8:0] OFF_SAVED = 9'h04C;
  localparam logic [8:0] OFF_BYTE  = 9'h080;
  localparam logic [8:0] OFF_PAIR  = 9'h0C0;
  localparam logic [8:0] OFF_QUAD  = 9'h0E0;
  localparam logic [8:0] OFF_ALU   = 9'h100;
  localparam logic [8:0] OFF_BUS   = 9'h104;
  localparam logic [8:0] OFF_TRAP  = 9'h108;
  localparam logic [8:0] OFF_STAT  = 9'h10C;
  // ==========================================================
  // flag and control word layout
  localparam int          FCW_SEG = 15;
  localparam int          FCW_SYS = 14;
  localparam int          FCW_C   = 7;
  localparam int          FCW_Z   = 6;
  localparam int          FCW_S   = 5;
  localparam int          FCW_V   = 4;
  localparam int          FCW_D   = 3;
  localparam int          FCW_H   = 2;
  localparam logic [15:0] FCW_RST = 16'h4000;
  // ==========================================================
  // status register bits, stack slots, sizes
  localparam int          STAT_IO_REF   = 0;
  localparam int          STAT_PRIV_REF = 1;
  localparam logic [3:0]  SP_HI         = 4'hE;
  localparam logic [3:0]  SP_LO         = 4'hF;
  localparam logic [15:0] PS_BYTES_SEG  = 16'h0008;
  localparam logic [15:0] PS_BYTES_NSEG = 16'h0004;
  // ==========================================================
  // bus status codes
  localparam logic [3:0] ST_INTERNAL = 4'h0;
  localparam logic [3:0] ST_IO       = 4'h2;
  localparam logic [3:0] ST_SPIO     = 4'h3;
  localparam logic [3:0] ST_DATA     = 4'h8;
  localparam logic [3:0] ST_STACK    = 4'h9;
  localparam logic [3:0] ST_IFETCH   = 4'hD;
  // ==========================================================
  // command encodings
  typedef enum logic [2:0] {
    ACC_FETCH = 3'h0,
    ACC_DATA  = 3'h1,
    ACC_STACK = 3'h2,
    ACC_IO    = 3'h3,
    ACC_SPIO  = 3'h4
  } crf_acc_e;
  typedef enum logic [1:0] {
    ALU_ADD = 2'h0,
    ALU_SUB = 2'h1,
    ALU_AND = 2'h2,
    ALU_XOR = 2'h3
  } crf_alu_e;
  typedef enum logic [4:0] {
    RG_NONE = 5'h01,
    RG_WORD = 5'h02,
    RG_BYTE = 5'h04,
    RG_PAIR = 5'h08,
    RG_QUAD = 5'h10
  } crf_rgn_e;
endpackage

/* File: test/crf_cpu_regs_tb_top.sv */
`timescale 1ns/1ns
module crf_cpu_regs_tb_top;
  import crf_pkg::*;
  logic        sys_clk;
  logic        srst;
  logic [8:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [3:0]  bus_status_code;
  logic [22:0] bus_address;
  logic        bus_strobe;
  logic        normal_system;
  logic [3:0]  p_space;
  logic [22:0] p_addr;
  logic [7:0]  p_count;
  int          fail_count;
  int          tests_run;

  crf_cpu_regs crf_cpu_regs_i (.sys_clk(sys_clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .bus_status_code(bus_status_code), .bus_address(bus_address),
    .bus_strobe(bus_strobe), .normal_system(normal_system));
  crf_space_decoder crf_space_decoder_i (.sys_clk(sys_clk), .srst(srst),
    .bus_status_code(bus_status_code), .bus_address(bus_address), .bus_strobe(bus_strobe),
    .normal_system(normal_system), .space_q(p_space), .addr_q(p_addr), .count_q(p_count));

  // ==========================================================
  // checking and bus tasks
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // request held until waitrequest is sampled low; no latency assumed
  task automatic av_xfer(input logic wr, input logic [8:0] a, input logic [31:0] d,
                         output logic [31:0] q);
    int n;
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    if (n >= 50) begin
      chk("handshake", 32'h0, 32'h1);
      test_done();
    end
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic av_wr(input logic [8:0] a, input logic [31:0] d);
    logic [31:0] q;
    av_xfer(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [8:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] q;
    av_xfer(1'b0, a, 32'h0, q);
    chk(nm, q, exp);
  endtask

  task automatic wait_mode(input logic v);
    int n;
    n = 0;
    while (normal_system !== v && n < 8) begin
      @(posedge sys_clk);
      n++;
    end
    chk("mode pin", {31'h0, normal_system}, {31'h0, v});
  endtask

  task automatic bus_acc(input logic [2:0] k, input logic [22:0] a, input logic [3:0] code,
                         input logic [22:0] ea, input logic [3:0] sp);
    av_wr(OFF_BUS, {1'b0, a, 5'h00, k});
    @(posedge sys_clk);
    chk("strobe", {31'h0, bus_strobe}, 32'h1);
    chk("code", {28'h0, bus_status_code}, {28'h0, code});
    chk("address", {9'h0, bus_address}, {9'h0, ea});
    @(posedge sys_clk);
    chk("strobe end", {31'h0, bus_strobe}, 32'h0);
    chk("space", {28'h0, p_space}, {28'h0, sp});
    chk("space addr", {9'h0, p_addr}, {9'h0, ea});
  endtask

  // ==========================================================
  // scenarios
  task automatic t_alias();
    logic [15:0] w [8];
    for (int k = 0; k < 8; k++) begin
      w[k] = 16'hA050 | {4'h0, 4'(k), 4'h0, 4'(k)};
      av_wr(OFF_WORD + 9'(4 * k), {16'h0, w[k]});
    end
    for (int k = 0; k < 8; k++) begin
      rd_chk(OFF_BYTE + 9'(8 * k), {24'h0, w[k][15:8]}, "byte high");
      rd_chk(OFF_BYTE + 9'(8 * k + 4), {24'h0, w[k][7:0]}, "byte low");
    end
    for (int k = 0; k < 4; k++)
      rd_chk(OFF_PAIR + 9'(4 * k), {w[2*k], w[2*k+1]}, "pair");
    for (int q = 0; q < 2; q++) begin
      rd_chk(OFF_QUAD + 9'(8 * q), {w[4*q], w[4*q+1]}, "quad upper");
      rd_chk(OFF_QUAD + 9'(8 * q + 4), {w[4*q+2], w[4*q+3]}, "quad lower");
    end
    av_wr(OFF_BYTE + 9'h00C, 32'h0000003C);
    rd_chk(OFF_WORD + 9'h004, {16'h0, w[1][15:8], 8'h3C}, "byte write");
    av_wr(OFF_WORD + 9'h034, 32'h00009ABC);
    rd_chk(OFF_WORD + 9'h034, 32'h00009ABC, "word r13");
    rd_chk(9'h1F0, 32'h0, "unmapped");
  endtask

  task automatic t_alu();
    logic [31:0] f;
    av_wr(OFF_WORD + 9'h008, 32'h7FFF);
    av_wr(OFF_WORD + 9'h00C, 32'h0001);
    av_wr(OFF_ALU, 32'h0320);
    rd_chk(OFF_WORD + 9'h008, 32'h8000, "add sum");
    rd_chk(OFF_FCW, 32'hC034, "add overflow flags");
    av_wr(OFF_WORD + 9'h010, 32'hFFFF);
    av_wr(OFF_WORD + 9'h014, 32'h0001);
    av_wr(OFF_ALU, 32'h0540);
    rd_chk(OFF_FCW, 32'hC0C4, "add carry flags");
    av_wr(OFF_WORD + 9'h018, 32'h0001);
    av_wr(OFF_WORD + 9'h01C, 32'h0001);
    av_wr(OFF_ALU, 32'h0761);
    av_xfer(1'b0, OFF_FCW, 32'h0, f);
    chk("sub flags", f & 32'h78, 32'h48);
    // byte xor of the two halves of word 2: odd parity, then zero with even parity
    av_wr(OFF_ALU, 32'h0457);
    rd_chk(OFF_WORD + 9'h008, 32'h8080, "xor result");
    av_xfer(1'b0, OFF_FCW, 32'h0, f);
    chk("xor odd flags", f & 32'h70, 32'h20);
    av_wr(OFF_ALU, 32'h0457);
    av_xfer(1'b0, OFF_FCW, 32'h0, f);
    chk("xor even flags", f & 32'h70, 32'h50);
    // word and of word 2 with itself: sign set, parity/overflow left alone
    av_wr(OFF_ALU, 32'h0222);
    rd_chk(OFF_WORD + 9'h008, 32'h8000, "and result");
    rd_chk(OFF_FCW, 32'hC038, "and flags");
  endtask

  task automatic t_bus();
    av_wr(OFF_WORD + 9'h038, 32'h0012);
    av_wr(OFF_WORD + 9'h03C, 32'h3400);
    bus_acc(3'h0, 23'h7ABCDE, ST_IFETCH, 23'h7ABCDE, 4'h0);
    bus_acc(3'h1, 23'h012345, ST_DATA, 23'h012345, 4'h1);
    bus_acc(3'h2, 23'h000000, ST_STACK, 23'h123400, 4'h2);
    bus_acc(3'h3, 23'h7FABCD, ST_IO, 23'h00ABCD, 4'h3);
    bus_acc(3'h4, 23'h7F1234, ST_SPIO, 23'h001234, 4'h4);
    av_wr(OFF_PC, 32'h1234);
    rd_chk(OFF_PC, 32'h1234, "program counter");
  endtask

  task automatic t_trap();
    logic [31:0] f;
    av_xfer(1'b0, OFF_FCW, 32'h0, f);
    chk("flag word before trap", f, 32'hC038);
    av_wr(OFF_TRAP, 32'h0);
    rd_chk(OFF_SAVED, 32'hC038, "saved flag word");
    rd_chk(OFF_WORD + 9'h03C, 32'h33F8, "system stack after trap");
    wait_mode(1'b0);
  endtask

  task automatic t_normal();
    av_wr(OFF_FCW, 32'h8000);
    wait_mode(1'b1);
    av_wr(OFF_WORD + 9'h03C, 32'h5555);
    rd_chk(OFF_WORD + 9'h03C, 32'h5555, "normal stack slot");
    rd_chk(OFF_FCW, 32'h0, "hidden flag word");
    av_wr(OFF_FCW, 32'hC000);
    rd_chk(OFF_STAT, 32'h2, "special write refused");
    chk("mode kept", {31'h0, normal_system}, 32'h1);
    av_wr(OFF_BUS, {1'b0, 23'h001111, 5'h00, 3'h3});
    repeat (3) begin
      @(posedge sys_clk);
      chk("refused strobe", {31'h0, bus_strobe}, 32'h0);
    end
    chk("refused code", {28'h0, bus_status_code}, 32'h0);
    rd_chk(OFF_STAT, 32'h3, "port refused");
    bus_acc(3'h1, 23'h000077, ST_DATA, 23'h000077, 4'h9);
    av_wr(OFF_BUS, 32'h0000_0005);
    @(posedge sys_clk);
    chk("kind 5 strobe", {31'h0, bus_strobe}, 32'h0);
    chk("kind 5 code", {28'h0, bus_status_code}, 32'h0);
    av_wr(OFF_STAT, 32'h3);
    rd_chk(OFF_STAT, 32'h0, "status cleared");
    av_wr(OFF_TRAP, 32'h0);
    wait_mode(1'b0);
    rd_chk(OFF_SAVED, 32'h8000, "saved normal word");
    rd_chk(OFF_WORD + 9'h03C, 32'h33F0, "system slot");
    rd_chk(OFF_NSP, 32'h00005555, "normal pointer special");
    chk("strobe count", {24'h0, p_count}, 32'h6);
  endtask

  // ==========================================================
  // clock, reset, sequence
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial begin
    srst          = 1'b1;
    avs_address   = 9'h000;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0;
    fail_count    = 0;
    tests_run     = 0;
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    chk("reset mode pin", {31'h0, normal_system}, 32'h0);
    rd_chk(OFF_FCW, 32'hC000, "reset flag word");
    t_alias();
    t_alu();
    t_bus();
    t_trap();
    t_normal();
    test_done();
  end
endmodule

/* File: test/crf_space_decoder.sv */
`timescale 1ns/1ns
// ==========================================================
// external decode: turns each strobed access into a space
module crf_space_decoder
  import crf_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic [3:0]  bus_status_code,
  input  wire logic [22:0] bus_address,
  input  wire logic        bus_strobe,
  input  wire logic        normal_system,
  output logic      [3:0]  space_q,
  output logic      [22:0] addr_q,
  output logic      [7:0]  count_q
);
  // space_q: bit3 normal mode, bits 2:0 access kind, 7 for a code no space owns
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      space_q <= 4'h0;
      addr_q  <= 23'h000000;
      count_q <= 8'h00;
    end else if (bus_strobe) begin
      count_q <= count_q + 8'h01;
      addr_q  <= bus_address;
      case (bus_status_code)
        ST_IFETCH: space_q <= {normal_system, 3'h0};
        ST_DATA:   space_q <= {normal_system, 3'h1};
        ST_STACK:  space_q <= {normal_system, 3'h2};
        ST_IO:     space_q <= {normal_system, 3'h3};
        ST_SPIO:   space_q <= {normal_system, 3'h4};
        default:   space_q <= {normal_system, 3'h7};
      endcase
    end
  end
endmodule
